// [fdc_sep_pkg.sv]
package fdc_sep_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CORE_CLK_MHZ = 200;
    localparam int NCO_NOM_KHZ = 2000;
    localparam int NCO_WIDTH = 32;
    // Phase step per core cycle for 2.0 MHz nominal: 2^32 * 2000 / 200000
    localparam logic [31:0] NCO_NOM_INC = 32'h028F5C29;
    localparam logic [31:0] NCO_TRIM_STEP = 32'h00004000;
    localparam logic [31:0] NCO_TRIM_MAX = 32'h00400000;

    localparam int REF_PW_SMALL_SD_NS = 2000;
    localparam int REF_PW_MID_NS = 1000;
    localparam int REF_PW_LARGE_DD_NS = 500;
    localparam int REF_PW_SMALL_SD_CYC = REF_PW_SMALL_SD_NS * CORE_CLK_MHZ / 1000;
    localparam int REF_PW_MID_CYC = REF_PW_MID_NS * CORE_CLK_MHZ / 1000;
    localparam int REF_PW_LARGE_DD_CYC = REF_PW_LARGE_DD_NS * CORE_CLK_MHZ / 1000;

    localparam int DATA_PW_NS = 250;
    localparam int DATA_PW_CYC = DATA_PW_NS * CORE_CLK_MHZ / 1000;

    // Oscillator ticks per double-rate half period (single rate is halved again)
    localparam logic [2:0] DIV_SMALL_SD = 3'h4;
    localparam logic [2:0] DIV_MID = 3'h2;
    localparam logic [2:0] DIV_LARGE_DD = 3'h1;

    localparam int FIFO_WIDTH = 2;
    localparam int FIFO_DEPTH = 8;

    // ----------------------------------------
    // Port addresses
    // ----------------------------------------
    localparam logic [7:0] PORT_DMA_ACK = 8'h10;
    localparam logic [7:0] PORT_XFER_END = 8'h14;

    typedef struct packed {
        logic large_drive;
        logic double_density;
    } media_cfg_s;

    typedef struct packed {
        logic [7:0] addr;
        logic io_read;
        logic io_write;
        logic dma_cycle;
    } io_cycle_s;

    typedef struct packed {
        logic bit_value;
        logic double_density;
    } enc_word_s;

    function automatic logic [1:0] media_sel(input media_cfg_s cfg);
        if (!cfg.large_drive && !cfg.double_density) begin
            return 2'h0;
        end else if (cfg.large_drive && cfg.double_density) begin
            return 2'h2;
        end
        return 2'h1;
    endfunction

endpackage

// [fdc_sep_fifo.sv]
`timescale 1ns/100ps
module fdc_sep_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 8
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } fifo_state_s;

    fifo_state_s state_reg;
    fifo_state_s state_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign o_in_ready = (state_reg.count != (AW+1)'(DEPTH));
    assign o_out_valid = (state_reg.count != '0);
    assign o_out_data = mem[state_reg.rd_ptr];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        state_next = state_reg;
        if (push) begin
            state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            state_next.count = state_reg.count + 1'b1;
        end else if (pop && !push) begin
            state_next.count = state_reg.count - 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Storage has no reset; only the pointers and count need a defined value
    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem[state_reg.wr_ptr] <= i_in_data;
        end
    end
endmodule // fdc_sep_fifo

// [fdc_sep_nco.sv]
`timescale 1ns/100ps
module fdc_sep_nco (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_early,
    input wire logic i_late,
    output logic o_tick
);
    import fdc_sep_pkg::*;

    typedef struct packed {
        logic [NCO_WIDTH-1:0] phase;
        logic [31:0] trim;
        logic tick;
    } nco_state_s;

    nco_state_s state_reg;
    nco_state_s state_next;
    logic [NCO_WIDTH:0] sum;

    assign o_tick = state_reg.tick;

    always_comb begin
        state_next = state_reg;
        if (i_early && !i_late && (state_reg.trim != NCO_TRIM_MAX)) begin
            state_next.trim = state_reg.trim + NCO_TRIM_STEP;
        end else if (i_late && !i_early && (state_reg.trim != (32'h0 - NCO_TRIM_MAX))) begin
            state_next.trim = state_reg.trim - NCO_TRIM_STEP;
        end
        sum = {1'b0, state_reg.phase} + {1'b0, NCO_NOM_INC + state_reg.trim};
        state_next.phase = sum[NCO_WIDTH-1:0];
        state_next.tick = sum[NCO_WIDTH];
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule // fdc_sep_nco

// [fdc_data_separator.sv]
`timescale 1ns/100ps

// Summary of operation
// - Each drive read pulse yields one fixed-width data pulse to the controller.
// - Each read pulse also yields a quarter-clock-period phase reference pulse.
// - Reference width 2.0, 1.0 or 0.5 us by drive size and density.
// - Tracking oscillator at nominal 2.0 MHz, divided to double and single rate.
// - Divider rates 250/125, 500/250, 1000/500 kHz by media selection.
// - Single-rate divider output goes to the controller as read clock.
// - Write clock is 250, 500 or 1000 kHz by media selection.
// - Two-flop detector compares reference with inverted double-rate clock, early or late.
// - Loop steers oscillator so pulses sit at the start of a high or low read-clock half.
// - Port 14H read at transfer end becomes the transfer end strobe.
// - Any DMA access to port 10H asserts the DMA acknowledge strobe.
// - FM writes a clock pulse in every bit cell plus data pulses.
// - MFM records a one mid-cell and a zero at cell start.
module fdc_data_separator
    import fdc_sep_pkg::*;
#(
    parameter int FIFO_W = FIFO_WIDTH,
    parameter int FIFO_D = FIFO_DEPTH
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire fdc_sep_pkg::media_cfg_s i_media,
    input wire logic i_drive_read_pulse,
    input wire fdc_sep_pkg::io_cycle_s i_io,
    input wire logic i_wr_valid,
    input wire logic i_wr_bit,
    output logic o_wr_ready,
    output logic o_read_data,
    output logic o_read_clock,
    output logic o_write_clock,
    output logic o_write_pulse,
    output logic o_early,
    output logic o_late,
    output logic o_dma_acknowledge_strobe,
    output logic o_transfer_end_strobe
);
    import fdc_sep_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    localparam int FILL_W = $clog2(FIFO_D) + 1;

    typedef enum logic [1:0] {ENC_IDLE, ENC_CLOCK, ENC_DATA} enc_e;

    typedef struct packed {
        media_cfg_s media;
        logic pulse_prev;
        logic [15:0] data_cnt;
        logic [15:0] ref_cnt;
        logic ref_pulse;
        logic ref_prev;
        logic [2:0] div_cnt;
        logic dbl_clk;
        logic sgl_clk;
        logic dbl_prev;
        logic early;
        logic late;
        logic read_data;
        logic write_clock;
        logic write_pulse;
        logic [2:0] wdiv_cnt;
        logic wtick;
        enc_e enc;
        logic cell_half;
        logic cur_bit;
        logic [FILL_W-1:0] fill;
        logic wr_ready;
        logic dma_ack;
        logic xfer_end;
    } sep_state_s;

    sep_state_s state_reg;
    sep_state_s state_next;

    logic nco_tick;
    logic fifo_valid;
    logic fifo_pop;
    logic wr_push;
    logic [FIFO_W-1:0] fifo_data;
    enc_word_s enc_in;
    enc_word_s enc_out;
    logic read_edge;
    logic [15:0] ref_len;
    logic [2:0] div_len;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Reference width per media
    function automatic logic [15:0] ref_width(input media_cfg_s cfg);
        unique case (media_sel(cfg))
            2'h0: return 16'(REF_PW_SMALL_SD_CYC);
            2'h2: return 16'(REF_PW_LARGE_DD_CYC);
            default: return 16'(REF_PW_MID_CYC);
        endcase
    endfunction

    function automatic logic [2:0] div_ratio(input media_cfg_s cfg);
        unique case (media_sel(cfg))
            2'h0: return DIV_SMALL_SD;
            2'h2: return DIV_LARGE_DD;
            default: return DIV_MID;
        endcase
    endfunction

    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    fdc_sep_nco u_nco (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_early(state_reg.early),
        .i_late(state_reg.late),
        .o_tick(nco_tick)
    );

    assign enc_in.bit_value = i_wr_bit;
    assign enc_in.double_density = state_reg.media.double_density;
    assign enc_out = enc_word_s'(fifo_data);

    // Bits queue here so software-side bursts do not stall the bit-cell timing
    fdc_sep_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_D)
    ) u_fifo (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_in_valid(wr_push),
        .o_in_ready(),
        .i_in_data(FIFO_W'(enc_in)),
        .o_out_valid(fifo_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_data)
    );

    assign read_edge = i_drive_read_pulse && !state_reg.pulse_prev;
    assign wr_push = i_wr_valid && state_reg.wr_ready;
    assign ref_len = ref_width(state_reg.media);
    assign div_len = div_ratio(state_reg.media);
    // A new bit is taken only at a write-clock cell boundary
    assign fifo_pop = state_reg.wtick && !state_reg.cell_half && fifo_valid;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.media = i_media;
        state_next.pulse_prev = i_drive_read_pulse;

        if (read_edge) begin
            state_next.data_cnt = 16'(DATA_PW_CYC);
        end else if (state_reg.data_cnt != 16'h0000) begin
            state_next.data_cnt = state_reg.data_cnt - 16'h0001;
        end
        state_next.read_data = (state_next.data_cnt != 16'h0000);

        if (read_edge) begin
            state_next.ref_cnt = ref_len;
        end else if (state_reg.ref_cnt != 16'h0000) begin
            state_next.ref_cnt = state_reg.ref_cnt - 16'h0001;
        end
        state_next.ref_pulse = (state_next.ref_cnt != 16'h0000);
        state_next.ref_prev = state_reg.ref_pulse;

        state_next.dbl_prev = state_reg.dbl_clk;
        if (nco_tick) begin
            if (state_reg.div_cnt + 3'h1 >= div_len) begin
                state_next.div_cnt = 3'h0;
                state_next.dbl_clk = !state_reg.dbl_clk;
                // Single-rate clock toggles on double-rate falls
                if (state_reg.dbl_clk) begin
                    state_next.sgl_clk = !state_reg.sgl_clk;
                end
            end else begin
                state_next.div_cnt = state_reg.div_cnt + 3'h1;
            end
        end

        // Early/late flops: set by first event, cleared by pairing
        // Late pushes frequency down, early pushes up to centre pulses
        if (state_reg.ref_pulse && !state_reg.ref_prev) begin
            if (!state_reg.dbl_clk) begin
                state_next.late = 1'b1;
            end else begin
                state_next.early = 1'b1;
            end
        end
        if (!state_reg.ref_pulse && state_reg.ref_prev) begin
            state_next.early = 1'b0;
            state_next.late = 1'b0;
        end
        if (state_reg.dbl_prev && !state_reg.dbl_clk) begin
            state_next.early = 1'b0;
        end

        // Write clock, one half-cycle per divider period
        state_next.wtick = 1'b0;
        if (nco_tick) begin
            if (state_reg.wdiv_cnt + 3'h1 >= div_len) begin
                state_next.wdiv_cnt = 3'h0;
                state_next.write_clock = !state_reg.write_clock;
                state_next.wtick = 1'b1;
            end else begin
                state_next.wdiv_cnt = state_reg.wdiv_cnt + 3'h1;
            end
        end

        // Bit-cell encoder, two write-clock halves per cell
        state_next.write_pulse = 1'b0;
        if (state_reg.wtick) begin
            state_next.cell_half = !state_reg.cell_half;
            if (!state_reg.cell_half) begin
                if (fifo_valid) begin
                    state_next.cur_bit = enc_out.bit_value;
                    state_next.enc = ENC_CLOCK;
                    if (!enc_out.double_density || !enc_out.bit_value) begin
                        state_next.write_pulse = 1'b1;
                    end
                end else begin
                    state_next.enc = ENC_IDLE;
                end
            end else if (state_reg.enc == ENC_CLOCK) begin
                state_next.enc = ENC_DATA;
                state_next.write_pulse = state_reg.cur_bit;
            end
        end

        // Own copy of the buffer fill, so that ready leaves a flop
        if (wr_push && !fifo_pop) begin
            state_next.fill = state_reg.fill + 1'b1;
        end else if (fifo_pop && !wr_push) begin
            state_next.fill = state_reg.fill - 1'b1;
        end
        state_next.wr_ready = (state_next.fill != FILL_W'(FIFO_D));

        state_next.dma_ack = i_io.dma_cycle && (i_io.io_read || i_io.io_write)
                             && (i_io.addr == PORT_DMA_ACK);
        // Port read becomes transfer end strobe
        state_next.xfer_end = i_io.io_read && !i_io.dma_cycle
                              && (i_io.addr == PORT_XFER_END);
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_wr_ready = state_reg.wr_ready;
    assign o_read_data = state_reg.read_data;
    assign o_read_clock = state_reg.sgl_clk;
    assign o_write_clock = state_reg.write_clock;
    assign o_write_pulse = state_reg.write_pulse;
    assign o_early = state_reg.early;
    assign o_late = state_reg.late;
    assign o_dma_acknowledge_strobe = state_reg.dma_ack;
    assign o_transfer_end_strobe = state_reg.xfer_end;
endmodule // fdc_data_separator

// [fdc_sep_checker_assertions.sv]
`timescale 1ns/100ps
module fdc_sep_checker
    import fdc_sep_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire fdc_sep_pkg::media_cfg_s i_media,
    input wire logic i_drive_read_pulse,
    input wire fdc_sep_pkg::io_cycle_s i_io,
    input wire logic o_read_data,
    input wire logic o_read_clock,
    input wire logic o_write_clock,
    input wire logic o_write_pulse,
    input wire logic o_early,
    input wire logic o_late,
    input wire logic o_dma_acknowledge_strobe,
    input wire logic o_transfer_end_strobe
);
    // ----------
    // Helpers
    // ----------
    // Rates are judged in a band, since the loop may trim the oscillator
    logic [11:0] n;
    logic [11:0] run_reg;
    logic [11:0] wc_reg;
    logic [11:0] rc_reg;
    logic wp_reg;
    logic rp_reg;
    logic [1:0] seen_reg;
    logic dma_acknowledge_strobe_hit;
    logic end_hit;
    assign n = i_media.large_drive ? (i_media.double_density ? 12'h001 : 12'h002)
        : (i_media.double_density ? 12'h002 : 12'h004);
    assign dma_acknowledge_strobe_hit = i_io.dma_cycle && (i_io.io_read || i_io.io_write)
        && i_io.addr == PORT_DMA_ACK;
    assign end_hit = i_io.io_read && !i_io.dma_cycle && i_io.addr == PORT_XFER_END;
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            run_reg <= 12'h000;
            wc_reg <= 12'h000;
            rc_reg <= 12'h000;
            wp_reg <= 1'b0;
            rp_reg <= 1'b0;
            seen_reg <= 2'h0;
        end else begin
            run_reg <= o_read_data ? run_reg + 12'h001 : 12'h000;
            wc_reg <= (o_write_clock != wp_reg) ? 12'h001 : wc_reg + 12'h001;
            rc_reg <= (o_read_clock != rp_reg) ? 12'h001 : rc_reg + 12'h001;
            wp_reg <= o_write_clock;
            rp_reg <= o_read_clock;
            seen_reg <= seen_reg | {o_read_clock != rp_reg, o_write_clock != wp_reg};
        end
    end
    // ----------
    // Properties
    // ----------
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_reset_n);
    a_dma_acknowledge_strobe_follow: assert property (dma_acknowledge_strobe_hit |=> o_dma_acknowledge_strobe)
        else $error("dma acknowledge strobe missing");
    a_dma_acknowledge_strobe_only: assert property (!dma_acknowledge_strobe_hit |=> !o_dma_acknowledge_strobe)
        else $error("dma acknowledge strobe without access");
    a_end_follow: assert property (end_hit |=> o_transfer_end_strobe)
        else $error("transfer end strobe missing");
    a_end_only: assert property (!end_hit |=> !o_transfer_end_strobe)
        else $error("transfer end strobe without read");
    a_pulse_answer: assert property ($rose(i_drive_read_pulse) |-> ##[1:3] o_read_data)
        else $error("read data pulse missing");
    a_pulse_width: assert property ($fell(o_read_data) |-> run_reg >= DATA_PW_CYC)
        else $error("read data pulse too short");
    a_wclk_rate: assert property (o_write_clock != wp_reg && seen_reg[0] |->
        wc_reg >= n * 12'h058 && wc_reg <= n * 12'h071) else $error("write clock rate off");
    a_rclk_rate: assert property (o_read_clock != rp_reg && seen_reg[1] |->
        rc_reg >= n * 12'h0B0 && rc_reg <= n * 12'h0E2) else $error("read clock rate off");
    a_phase_excl: assert property (!(o_early && o_late))
        else $error("early and late together");
    a_wpulse_single: assert property (o_write_pulse |=> !o_write_pulse)
        else $error("write pulse longer than one cycle");
endmodule // fdc_sep_checker

bind fdc_data_separator fdc_sep_checker i_chk (.i_core_clk, .i_reset_n, .i_media,
    .i_drive_read_pulse, .i_io, .o_read_data, .o_read_clock, .o_write_clock,
    .o_write_pulse, .o_early, .o_late, .o_dma_acknowledge_strobe, .o_transfer_end_strobe);

// [fdc_drive_model.sv]
`timescale 1ns/100ps
module fdc_drive_model (
    input wire logic i_core_clk,
    input wire logic i_start,
    input wire logic [15:0] i_gap,
    input wire logic [15:0] i_width,
    input wire logic [3:0] i_count,
    output logic o_pulse
);
    // ----------
    // Read data
    // ----------
    // Line idles low between flux pulses; width varies to stress reshaping
    initial begin
        o_pulse = 1'b0;
        forever begin
            @(posedge i_core_clk);
            if (i_start) begin
                repeat (i_count) begin
                    @(negedge i_core_clk);
                    o_pulse = 1'b1;
                    repeat (i_width) @(negedge i_core_clk);
                    o_pulse = 1'b0;
                    repeat (i_gap) @(negedge i_core_clk);
                end
            end
        end
    end
endmodule // fdc_drive_model

// [fdc_data_separator_bench.sv]
`timescale 1ns/100ps
module fdc_data_separator_bench;
    import fdc_sep_pkg::*;
    // ----------
    // Signals
    // ----------
    logic i_core_clk;
    logic i_reset_n;
    media_cfg_s i_media;
    logic i_drive_read_pulse;
    io_cycle_s i_io;
    logic i_wr_valid;
    logic i_wr_bit;
    logic o_wr_ready, o_read_data, o_read_clock, o_write_clock, o_write_pulse;
    logic o_early, o_late, o_dma_acknowledge_strobe, o_transfer_end_strobe;
    logic drv_start;
    logic [15:0] drv_gap;
    logic [15:0] drv_width;
    logic [3:0] drv_count;
    int errors;
    int tests_run;
    fdc_data_separator i_dut (.i_core_clk, .i_reset_n, .i_media, .i_drive_read_pulse, .i_io,
        .i_wr_valid, .i_wr_bit, .o_wr_ready, .o_read_data, .o_read_clock, .o_write_clock,
        .o_write_pulse, .o_early, .o_late, .o_dma_acknowledge_strobe, .o_transfer_end_strobe);
    fdc_drive_model i_drive (.i_core_clk, .i_start(drv_start), .i_gap(drv_gap),
        .i_width(drv_width), .i_count(drv_count), .o_pulse(i_drive_read_pulse));
    // ----------
    // Tasks
    // ----------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (exp !== got) begin
            errors++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic results();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic do_reset(input media_cfg_s m);
        @(negedge i_core_clk);
        i_reset_n = 1'b0;
        i_media = m;
        repeat (20) @(negedge i_core_clk);
        i_reset_n = 1'b1;
    endtask
    // First half period is skipped, it may start mid-cycle
    task automatic half_period(input logic rd, output int cyc);
        int t;
        int k;
        logic last;
        t = 0;
        cyc = 0;
        last = rd ? o_read_clock : o_write_clock;
        for (k = 0; k < 4000 && t < 2; k++) begin
            @(negedge i_core_clk);
            if (t == 1) cyc++;
            if ((rd ? o_read_clock : o_write_clock) !== last) begin
                last = ~last;
                t++;
            end
        end
        if (t < 2) begin
            errors++;
            results();
        end
    endtask
    task automatic read_pulses(input logic [3:0] cnt, input logic [15:0] w);
        int rises, highs, el, k;
        logic last;
        rises = 0;
        highs = 0;
        el = 0;
        last = o_read_data;
        drv_count = cnt;
        drv_width = w;
        drv_start = 1'b1;
        @(negedge i_core_clk);
        drv_start = 1'b0;
        for (k = 0; k < cnt * (w + 16'h0097) + 100; k++) begin
            @(negedge i_core_clk);
            highs += (o_read_data === 1'b1);
            el += (o_early === 1'b1 || o_late === 1'b1);
            if (o_read_data === 1'b1 && last !== 1'b1) rises++;
            last = o_read_data;
        end
        chk("read data pulses", cnt, rises);
        chk("read data high cycles", cnt * DATA_PW_CYC, highs);
        chk("phase detector active", 1, el > 0);
    endtask
    task automatic media_rates();
        int n, h, i;
        for (i = 0; i < 4; i++) begin
            n = (i == 3) ? 1 : (i == 0) ? 4 : 2;
            do_reset(media_cfg_s'(i[1:0]));
            half_period(1'b0, h);
            chk("write clock half", 1, h >= n * 88 && h <= n * 113);
            half_period(1'b1, h);
            chk("read clock half", 1, h >= n * 176 && h <= n * 226);
            read_pulses(4'h3, 16'h0003);
            read_pulses(4'h2, 16'h0050);
        end
    endtask
    task automatic io_strobes();
        io_cycle_s tbl [6] = '{'{PORT_DMA_ACK, 1'b0, 1'b1, 1'b1},
            '{PORT_DMA_ACK, 1'b1, 1'b0, 1'b0}, '{PORT_XFER_END, 1'b1, 1'b0, 1'b0},
            '{PORT_XFER_END, 1'b1, 1'b0, 1'b1}, '{8'h11, 1'b0, 1'b0, 1'b1},
            '{PORT_XFER_END, 1'b0, 1'b1, 1'b0}};
        logic [1:0] want [6] = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0};
        int i, k, nd, nt;
        // Data acknowledges come before the closing count read
        for (i = 0; i < 6; i++) begin
            nd = 0;
            nt = 0;
            for (k = 0; k < 8; k++) begin
                i_io = (k < 3) ? tbl[i] : '0;
                @(negedge i_core_clk);
                nd += (o_dma_acknowledge_strobe === 1'b1);
                nt += (o_transfer_end_strobe === 1'b1);
            end
            chk("dma acknowledge cycles", want[i][1] ? 3 : 0, nd);
            chk("transfer end cycles", want[i][0] ? 3 : 0, nt);
        end
    endtask
    task automatic write_bits(input media_cfg_s m, input logic [9:0] bits, input int exp);
        int i, k, p, q, idle;
        do_reset(m);
        i = 0;
        p = 0;
        q = 0;
        idle = 0;
        i_wr_valid = 1'b1;
        for (k = 0; k < 9000 && i < 10; k++) begin
            i_wr_bit = bits[9 - i];
            if (o_wr_ready === 1'b1) i++;
            else q++;
            @(negedge i_core_clk);
            p += (o_write_pulse === 1'b1);
        end
        i_wr_valid = 1'b0;
        for (k = 0; k < 20000 && idle < 2000; k++) begin
            @(negedge i_core_clk);
            idle = (o_write_pulse === 1'b1) ? 0 : idle + 1;
            p += (o_write_pulse === 1'b1);
        end
        if (i < 10 || idle < 2000) begin
            errors++;
            results();
        end
        chk("write buffer refused", 1, q > 0);
        chk("write pulse count", exp, p);
    endtask
    // ----------
    // Sequence
    // ----------
    initial begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end
    initial begin
        #400000;
        errors++;
        results();
    end
    initial begin
        errors = 0;
        tests_run = 0;
        i_reset_n = 1'b0;
        i_media = '0;
        i_io = '0;
        i_wr_valid = 1'b0;
        i_wr_bit = 1'b0;
        drv_start = 1'b0;
        drv_gap = 16'h0096;
        drv_width = 16'h0003;
        drv_count = 4'h0;
        media_rates();
        io_strobes();
        write_bits(2'h2, 10'h2CE, 16);
        write_bits(2'h3, 10'h263, 10);
        results();
    end
endmodule // fdc_data_separator_bench
